// File: rtl/bwc_pkg.sv
/*
  Package for the bridge window configuration registers: dword offsets,
  field positions, fixed read values, reset values and the state record.
  Assumes byte addresses on the configuration port, dword aligned.
*/
package bwc_pkg;

	// ------------------------------------------------------------
	// dword offsets in configuration space
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_PF_LOW   = 8'h24;
	localparam logic [7:0] OFF_PF_BOT_H = 8'h28;
	localparam logic [7:0] OFF_PF_TOP_H = 8'h2c;
	localparam logic [7:0] OFF_IO_HIGH  = 8'h30;
	localparam logic [7:0] OFF_CAP      = 8'h34;
	localparam logic [7:0] OFF_IRQ      = 8'h3c;

	// ------------------------------------------------------------
	// fixed read values
	// ------------------------------------------------------------
	localparam logic [3:0] PF_ADDR64    = 4'h1;
	localparam logic [7:0] CAP_START    = 8'h40;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [11:0] RST_PF_FIELD = 12'h000;
	localparam logic [31:0] RST_HIGH32   = 32'h0000_0000;
	localparam logic [15:0] RST_IO_HIGH  = 16'h0000;
	localparam logic [7:0]  RST_IRQ_LINE = 8'h00;
	localparam logic [7:0]  RST_IRQ_PIN  = 8'h00;

	// ------------------------------------------------------------
	// field positions and implied low address bits
	// ------------------------------------------------------------
	localparam int          PF_BASE_LSB  = 4;
	localparam int          PF_LIMIT_LSB = 20;
	localparam int          PF_FLAG_HI   = 16;
	localparam int          IO_TOP_LSB   = 16;
	localparam int          IRQ_PIN_LSB  = 8;
	localparam logic [19:0] PF_BOT_FILL  = 20'h00000;
	localparam logic [19:0] PF_TOP_FILL  = 20'hfffff;

	// writable bit masks per dword
	localparam logic [31:0] WM_PF_LOW    = 32'hfff0_fff0;
	localparam logic [31:0] WM_ALL       = 32'hffff_ffff;
	localparam logic [31:0] WM_IRQ       = 32'h0000_00ff;
	localparam logic [31:0] WM_NONE      = 32'h0000_0000;

	// ------------------------------------------------------------
	// whole state of the register bank
	// ------------------------------------------------------------
	typedef struct packed {
		logic        ds_s1;
		logic        ds_s2;
		logic [11:0] pf_base;
		logic [11:0] pf_limit;
		logic [31:0] pf_base_hi;
		logic [31:0] pf_limit_hi;
		logic [15:0] io_base_hi;
		logic [15:0] io_limit_hi;
		logic [7:0]  irq_line;
		logic [7:0]  irq_pin;
		logic [31:0] rdata;
		logic        rvalid;
		logic        mem_hit;
		logic        io_hit;
	} bwc_state_t;

endpackage

// File: rtl/bwc_win_cmp.sv
/*
  Inclusive address window compare, width set by parameter.
  Assumes base and limit already carry their implied low bits.
*/
`timescale 1ns/10ps
`default_nettype none

module bwc_win_cmp #(
	parameter int W = 32
) (
	// address under test
	input  wire logic [W-1:0] addr,
	// window bounds
	input  wire logic [W-1:0] base,
	input  wire logic [W-1:0] limit,
	// result
	output logic              hit
);

	// ------------------------------------------------------------
	// compare
	// ------------------------------------------------------------
	// base above limit leaves no address satisfying both sides, so the window is empty
	assign hit = (addr >= base) && (addr <= limit); // RULE_14

endmodule

`default_nettype wire

// File: rtl/bwc_be_merge.sv
/*
  Byte-lane write merge for one 32-bit configuration dword.
  Assumes the caller supplies the mask of writable bits.
*/
`timescale 1ns/10ps
`default_nettype none

module bwc_be_merge (
	// current and incoming data
	input  wire logic [31:0] old_word,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  be,
	input  wire logic [31:0] wmask,
	// merged result
	output logic [31:0]      new_word
);

	// ------------------------------------------------------------
	// per-lane merge
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic [7:0] lane_m;
			assign lane_m = wmask[g*8 +: 8] & {8{be[g]}};
			// read-only bits keep their old value whatever is written
			assign new_word[g*8 +: 8] = (wdata[g*8 +: 8] & lane_m) | // RULE_15
				(old_word[g*8 +: 8] & ~lane_m);
		end
	endgenerate

endmodule

`default_nettype wire

// File: rtl/bwc_regs.sv
/*
  Bridge window configuration registers of one switch port: prefetchable
  window bottom, top and upper halves, I/O window upper halves, capability start,
  interrupt routing line and pin, plus the window hit decode.
  Assumes configuration accesses and the default loader run on sys_clk,
  and that the lower I/O bounds come from the neighbouring registers.
*/
//
// Behaviour
// (RULE_01) prefetch limit bits 19:16 are read-only and always read 1h.
// (RULE_02) limit field gives window top bits 31:20; low twenty bits are ones.
// (RULE_03) dword 28h holds window bottom bits 63:32, read-write, resets zero.
// (RULE_04) dword 2Ch holds window top bits 63:32, read-write, resets zero.
// (RULE_05) prefetch base and limit steer memory forwarding; limit field resets zero.
// (RULE_06) bits 15:0 of 30h hold I/O bottom bits 31:16, reset zero.
// (RULE_07) bits 31:16 of 30h hold I/O top bits 31:16, reset zero.
// (RULE_08) extended I/O bounds steer I/O forwarding between interfaces.
// (RULE_09) capability start byte is read-only and returns 40h.
// (RULE_10) low byte of 3Ch is plain read-write routing line, reset zero.
// (RULE_11) interrupt pin byte at 15:8 is read-only to configuration writes.
// (RULE_12) pin byte resets zero; downstream ports may load a new default.
// (RULE_13) base field 15:4 of 24h gives bottom bits 31:20; low bits zero.
// (RULE_14) inside means at least base and at most limit; inverted is empty.
// (RULE_15) read-only writes ignored; shared dwords return each field in place.
//
`timescale 1ns/10ps
`default_nettype none

module bwc_regs (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,

	// configuration access
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	input  wire logic [3:0]  cfg_be,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_rvalid,

	// default loader for the pin byte
	input  wire logic        port_is_downstream,
	input  wire logic        ld_pin_valid,
	input  wire logic [7:0]  ld_pin_value,

	// lower I/O bounds from the neighbouring registers
	input  wire logic [15:0] io_base_low,
	input  wire logic [15:0] io_limit_low,

	// forwarding decode
	input  wire logic [63:0] mem_addr,
	input  wire logic [31:0] io_addr,
	output logic             mem_fwd_hit,
	output logic             io_fwd_hit,

	// routing line to the interrupt logic
	output logic [7:0]       irq_line_out
);

	import bwc_pkg::*;

	// ------------------------------------------------------------
	// state record and its next value
	// ------------------------------------------------------------
	bwc_state_t st_r;
	bwc_state_t st_nxt;

	// decoded dword match, shared by read, write and checks
	function automatic logic at_off(input logic [7:0] a, input logic [7:0] off);
		at_off = (a[7:2] == off[7:2]);
	endfunction

	// ------------------------------------------------------------
	// assembled window bounds
	// ------------------------------------------------------------
	logic [63:0] pf_bot64;
	logic [63:0] pf_top64;
	logic [31:0] io_bot32;
	logic [31:0] io_top32;
	logic        mem_in;
	logic        io_in;

	// bottom bits below the field are zero, top bits below it are ones
	assign pf_bot64 = {st_r.pf_base_hi, st_r.pf_base, PF_BOT_FILL}; // RULE_13 RULE_03
	assign pf_top64 = {st_r.pf_limit_hi, st_r.pf_limit, PF_TOP_FILL}; // RULE_02 RULE_04
	assign io_bot32 = {st_r.io_base_hi, io_base_low}; // RULE_06
	assign io_top32 = {st_r.io_limit_hi, io_limit_low}; // RULE_07

	// prefetchable memory window
	bwc_win_cmp #(
		.W (64)
	) u_mem_win (
		.addr  (mem_addr),
		.base  (pf_bot64),
		.limit (pf_top64),
		.hit   (mem_in)
	);

	// I/O window
	bwc_win_cmp #(
		.W (32)
	) u_io_win (
		.addr  (io_addr),
		.base  (io_bot32),
		.limit (io_top32),
		.hit   (io_in)
	);

	// ------------------------------------------------------------
	// read view of the addressed dword
	// ------------------------------------------------------------
	logic [31:0] cur_word;
	logic [31:0] cur_mask;
	logic [31:0] wr_word;

	// fields that share a dword (24h, 30h, 3Ch) each sit at their own bit positions inside it
	always_comb begin
		cur_word = 32'h0000_0000;
		cur_mask = WM_NONE;
		if (at_off(cfg_addr, OFF_PF_LOW)) begin
			cur_word = {st_r.pf_limit, PF_ADDR64, st_r.pf_base, PF_ADDR64}; // RULE_01 RULE_15
			cur_mask = WM_PF_LOW;
		end else if (at_off(cfg_addr, OFF_PF_BOT_H)) begin
			cur_word = st_r.pf_base_hi; // RULE_03
			cur_mask = WM_ALL;
		end else if (at_off(cfg_addr, OFF_PF_TOP_H)) begin
			cur_word = st_r.pf_limit_hi; // RULE_04
			cur_mask = WM_ALL;
		end else if (at_off(cfg_addr, OFF_IO_HIGH)) begin
			cur_word = {st_r.io_limit_hi, st_r.io_base_hi}; // RULE_06 RULE_07
			cur_mask = WM_ALL;
		end else if (at_off(cfg_addr, OFF_CAP)) begin
			cur_word = {24'h00_0000, CAP_START}; // RULE_09
		end else if (at_off(cfg_addr, OFF_IRQ)) begin
			// upper half belongs to the bridge control logic elsewhere
			cur_word = {16'h0000, st_r.irq_pin, st_r.irq_line}; // RULE_10 RULE_11
			cur_mask = WM_IRQ;
		end
	end

	// byte-lane merge, read-only bits protected by the mask
	bwc_be_merge u_merge (
		.old_word (cur_word),
		.wdata    (cfg_wdata),
		.be       (cfg_be),
		.wmask    (cur_mask),
		.new_word (wr_word)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// strap is a pin, so it passes two flops before use
		st_nxt.ds_s1 = port_is_downstream;
		st_nxt.ds_s2 = st_r.ds_s1;
		st_nxt.rvalid = cfg_rd;
		if (cfg_rd) begin
			st_nxt.rdata = cur_word; // RULE_15
		end
		if (cfg_wr) begin
			if (at_off(cfg_addr, OFF_PF_LOW)) begin
				st_nxt.pf_base = wr_word[PF_BASE_LSB +: 12]; // RULE_13
				st_nxt.pf_limit = wr_word[PF_LIMIT_LSB +: 12]; // RULE_02
			end
			if (at_off(cfg_addr, OFF_PF_BOT_H)) begin
				st_nxt.pf_base_hi = wr_word; // RULE_03
			end
			if (at_off(cfg_addr, OFF_PF_TOP_H)) begin
				st_nxt.pf_limit_hi = wr_word; // RULE_04
			end
			if (at_off(cfg_addr, OFF_IO_HIGH)) begin
				st_nxt.io_base_hi = wr_word[15:0]; // RULE_06
				st_nxt.io_limit_hi = wr_word[IO_TOP_LSB +: 16]; // RULE_07
			end
			if (at_off(cfg_addr, OFF_IRQ)) begin
				st_nxt.irq_line = wr_word[7:0]; // RULE_10
			end
		end
		// only the loader reaches the pin byte, and only on downstream ports
		if (ld_pin_valid && st_r.ds_s2) begin
			st_nxt.irq_pin = ld_pin_value; // RULE_12
		end
		// decode is registered so the compare path stays off the outputs
		st_nxt.mem_hit = mem_in; // RULE_05
		st_nxt.io_hit = io_in; // RULE_08
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_r.ds_s1 <= 1'b0;
			st_r.ds_s2 <= 1'b0;
			st_r.pf_base <= RST_PF_FIELD;
			st_r.pf_limit <= RST_PF_FIELD; // RULE_05
			st_r.pf_base_hi <= RST_HIGH32;
			st_r.pf_limit_hi <= RST_HIGH32;
			st_r.io_base_hi <= RST_IO_HIGH;
			st_r.io_limit_hi <= RST_IO_HIGH;
			st_r.irq_line <= RST_IRQ_LINE;
			st_r.irq_pin <= RST_IRQ_PIN; // RULE_12
			st_r.rdata <= 32'h0000_0000;
			st_r.rvalid <= 1'b0;
			st_r.mem_hit <= 1'b0;
			st_r.io_hit <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cfg_rdata = st_r.rdata;
	assign cfg_rvalid = st_r.rvalid;
	assign mem_fwd_hit = st_r.mem_hit;
	assign io_fwd_hit = st_r.io_hit;
	assign irq_line_out = st_r.irq_line;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// full-dword write to a given offset
	sequence s_full_wr(logic [7:0] off);
		cfg_wr && at_off(cfg_addr, off) && (cfg_be == 4'hf);
	endsequence

	// read request to a given offset
	sequence s_rd(logic [7:0] off);
		cfg_rd && at_off(cfg_addr, off);
	endsequence

	// read answer one cycle later
	sequence s_ans;
		cfg_rvalid;
	endsequence

	chk_pf_flag_bits: assert property ( // RULE_01
		s_rd(OFF_PF_LOW) |=> s_ans ##0
			(cfg_rdata[PF_FLAG_HI +: 4] == 4'h1) && (cfg_rdata[3:0] == 4'h1))
		else $error("prefetch addressing flag bits not read as one");

	chk_pf_top_edge: assert property ( // RULE_02
		(mem_addr == pf_top64) && (pf_bot64 <= pf_top64) |=> mem_fwd_hit)
		else $error("last byte of prefetch window not decoded as inside");

	chk_bot_hi_write: assert property ( // RULE_03
		s_full_wr(OFF_PF_BOT_H) ##1 s_rd(OFF_PF_BOT_H) |=>
			cfg_rdata == $past(cfg_wdata, 2))
		else $error("prefetch bottom upper half did not read back");

	chk_top_hi_write: assert property ( // RULE_04
		s_full_wr(OFF_PF_TOP_H) |=> pf_top64[63:32] == $past(cfg_wdata))
		else $error("prefetch top upper half not stored");

	chk_mem_window: assert property ( // RULE_05
		mem_fwd_hit |-> ($past(mem_addr) >= $past(pf_bot64)) &&
			($past(mem_addr) <= $past(pf_top64)))
		else $error("memory forward outside prefetch window");

	chk_io_lane_split: assert property ( // RULE_06 RULE_07
		cfg_wr && at_off(cfg_addr, OFF_IO_HIGH) && (cfg_be == 4'h3) |=>
			(io_bot32[31:16] == $past(cfg_wdata[15:0])) && $stable(io_top32[31:16]))
		else $error("I/O upper halves not split by byte lane");

	chk_io_window: assert property ( // RULE_08
		io_fwd_hit |-> ($past(io_addr) >= $past(io_bot32)) &&
			($past(io_addr) <= $past(io_top32)))
		else $error("I/O forward outside I/O window");

	chk_cap_start: assert property ( // RULE_09
		s_rd(OFF_CAP) ##1 s_ans |-> cfg_rdata == 32'h0000_0040)
		else $error("capability start not read as 40h");

	chk_line_store: assert property ( // RULE_10
		s_full_wr(OFF_IRQ) |=> irq_line_out == $past(cfg_wdata[7:0]))
		else $error("routing line byte not stored");

	chk_pin_read_only: assert property ( // RULE_11 RULE_15
		cfg_wr && at_off(cfg_addr, OFF_IRQ) && !ld_pin_valid |=> $stable(st_r.irq_pin))
		else $error("configuration write changed the pin byte");

	chk_pin_load: assert property ( // RULE_12
		ld_pin_valid && st_r.ds_s2 |=> st_r.irq_pin == $past(ld_pin_value))
		else $error("pin default load ignored on downstream port");

	chk_pin_upstream: assert property ( // RULE_12
		ld_pin_valid && !st_r.ds_s2 |=> $stable(st_r.irq_pin))
		else $error("pin default loaded on upstream port");

	chk_empty_window: assert property ( // RULE_14
		pf_bot64 > pf_top64 |=> !mem_fwd_hit)
		else $error("inverted prefetch window still decoded");

	// ------------------------------------------------------------
	// read answer timing and field placement
	// ------------------------------------------------------------
	// answer comes exactly one cycle after each read, never unasked
	chk_rvalid_after_rd: assert property ( // RULE_15
		cfg_rd |=> s_ans)
		else $error("read answer missing one cycle after request");

	chk_rvalid_unasked: assert property ( // RULE_15
		!cfg_rd |=> !cfg_rvalid)
		else $error("read answer raised without a request");

	// software may pick the data up late, so it must not drift
	chk_rdata_holds: assert property ( // RULE_15
		!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data changed without a read");

	// a full write of the shared dword lands both twelve-bit fields
	chk_base_field: assert property ( // RULE_13
		s_full_wr(OFF_PF_LOW) |=>
			pf_bot64[31:0] == {$past(cfg_wdata[PF_BASE_LSB +: 12]), PF_BOT_FILL})
		else $error("prefetch bottom field not stored with zero fill");

	chk_limit_field: assert property ( // RULE_02
		s_full_wr(OFF_PF_LOW) |=>
			pf_top64[31:0] == {$past(cfg_wdata[PF_LIMIT_LSB +: 12]), PF_TOP_FILL})
		else $error("prefetch top field not stored with ones fill");

	// ------------------------------------------------------------
	// window end points
	// ------------------------------------------------------------
	// end points are where an off-by-one in the compare would show
	chk_pf_bot_edge: assert property ( // RULE_13 RULE_14
		(mem_addr == pf_bot64) && (pf_bot64 <= pf_top64) |=> mem_fwd_hit)
		else $error("first byte of prefetch window not decoded as inside");

	chk_io_top_edge: assert property ( // RULE_08 RULE_14
		(io_addr == io_top32) && (io_bot32 <= io_top32) |=> io_fwd_hit)
		else $error("last address of I/O window not decoded as inside");

endmodule

`default_nettype wire

// File: bench/tb.sv
/*
  Self-checking bench for bwc_regs: register reset values, masked writes,
  loader override of the pin byte and both window hit decodes.
  Assumes bwc_pkg is compiled first and the design holds its own assertions.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
	import bwc_pkg::*;

	// ------------------------------------------------------------
	// ports and bench model of the register contents
	// ------------------------------------------------------------
	logic        sys_clk, resetn, cfg_wr, cfg_rd, cfg_rvalid;
	logic [7:0]  cfg_addr, ld_pin_value, irq_line_out;
	logic [31:0] cfg_wdata, cfg_rdata, io_addr;
	logic [3:0]  cfg_be;
	logic        port_is_downstream, ld_pin_valid, mem_fwd_hit, io_fwd_hit;
	logic [15:0] io_base_low, io_limit_low;
	logic [63:0] mem_addr;
	logic [11:0] m_pfb, m_pfl;
	logic [31:0] m_bh, m_lh, w;
	logic [15:0] m_iob, m_iol;
	logic [7:0]  m_line, m_pin;
	int          err_total, n_checks;
	logic [7:0]  offs [7] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h38};

	bwc_regs u_bwc_regs (.sys_clk(sys_clk), .resetn(resetn), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.port_is_downstream(port_is_downstream), .ld_pin_valid(ld_pin_valid),
		.ld_pin_value(ld_pin_value), .io_base_low(io_base_low),
		.io_limit_low(io_limit_low), .mem_addr(mem_addr), .io_addr(io_addr),
		.mem_fwd_hit(mem_fwd_hit), .io_fwd_hit(io_fwd_hit),
		.irq_line_out(irq_line_out));

	// 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// expectation functions
	// ------------------------------------------------------------
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		case ({a[7:2], 2'b00})
			OFF_PF_LOW:   exp_rd = {m_pfl, PF_ADDR64, m_pfb, PF_ADDR64};
			OFF_PF_BOT_H: exp_rd = m_bh;
			OFF_PF_TOP_H: exp_rd = m_lh;
			OFF_IO_HIGH:  exp_rd = {m_iol, m_iob};
			OFF_CAP:      exp_rd = {24'h000000, CAP_START};
			OFF_IRQ:      exp_rd = {16'h0000, m_pin, m_line};
			default:      exp_rd = 32'h0000_0000;
		endcase
	endfunction

	// only enabled lanes of writable bits take new data
	function automatic logic [31:0] mrg(input logic [31:0] o, d, wm, input logic [3:0] be);
		logic [31:0] n;
		n = (d & wm) | (o & ~wm);
		mrg = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) mrg[8*i +: 8] = n[8*i +: 8];
		end
	endfunction

	function automatic logic mhit(input logic [63:0] a);
		mhit = (a >= {m_bh, m_pfb, 20'h00000}) && (a <= {m_lh, m_pfl, 20'hfffff});
	endfunction

	function automatic logic ihit(input logic [31:0] a);
		ihit = (a >= {m_iob, io_base_low}) && (a <= {m_iol, io_limit_low});
	endfunction

	// ------------------------------------------------------------
	// compare tasks and closing
	// ------------------------------------------------------------
	task automatic chk_word(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t word got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t flag got %b exp %b", $time, g, e);
		end
	endtask

	task automatic complete_run();
		if (err_total == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// bus tasks, all entered at a falling edge
	// ------------------------------------------------------------
	task automatic do_reset();
		// strobes may still be up from the last transfer
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		resetn = 1'b0;
		repeat (6) @(negedge sys_clk);
		resetn = 1'b1;
		{m_pfb, m_pfl, m_bh, m_lh, m_iob, m_iol, m_line, m_pin} = '0;
	endtask

	// strobes stay up until another task takes the bus; a repeated write is a no-op
	task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] t;
		cfg_rd = 1'b0;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_be = be;
		cfg_wr = 1'b1;
		@(negedge sys_clk);
		case ({a[7:2], 2'b00})
			OFF_PF_LOW: begin
				w = mrg(exp_rd(a), d, WM_PF_LOW, be);
				m_pfb = w[15:4];
				m_pfl = w[31:20];
			end
			OFF_PF_BOT_H: m_bh = mrg(m_bh, d, WM_ALL, be);
			OFF_PF_TOP_H: m_lh = mrg(m_lh, d, WM_ALL, be);
			OFF_IO_HIGH:  {m_iol, m_iob} = mrg({m_iol, m_iob}, d, WM_ALL, be);
			OFF_IRQ: begin
				t = mrg({24'h0, m_line}, d, WM_IRQ, be);
				m_line = t[7:0];
			end
			default: ;
		endcase
	endtask

	// read data is checked in the cycle the answer pulse stands
	task automatic cfg_read(input logic [7:0] a);
		int k;
		cfg_wr = 1'b0;
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge sys_clk);
		k = 0;
		while (cfg_rvalid !== 1'b1 && k < 3) begin
			@(negedge sys_clk);
			k++;
		end
		chk_bit(cfg_rvalid, 1'b1);
		chk_word(cfg_rdata, exp_rd(a));
	endtask

	// hit flags answer one cycle after the address is sampled
	task automatic probe(input logic [63:0] m, input logic [31:0] i);
		mem_addr = m;
		io_addr = i;
		@(negedge sys_clk);
		chk_bit(mem_fwd_hit, mhit(m));
		chk_bit(io_fwd_hit, ihit(i));
	endtask

	task automatic edges();
		logic [63:0] mb, mt;
		logic [31:0] ib, it;
		mb = {m_bh, m_pfb, 20'h00000};
		mt = {m_lh, m_pfl, 20'hfffff};
		ib = {m_iob, io_base_low};
		it = {m_iol, io_limit_low};
		probe(mb, ib);
		probe(mt, it);
		probe(mb - 64'h1, ib - 32'h1);
		probe(mt + 64'h1, it + 32'h1);
		probe({$urandom, $urandom}, $urandom);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{cfg_addr, cfg_wdata, cfg_be, ld_pin_valid, ld_pin_value} = '0;
		{port_is_downstream, io_base_low, io_limit_low, mem_addr, io_addr} = '0;
		err_total = 0;
		n_checks = 0;
		void'($urandom(32'heb1e952e));
		do_reset();
		foreach (offs[i]) cfg_read(offs[i]);
		cfg_read(8'h3c);
		// read-only places and split lanes first, then random traffic
		cfg_write(8'h24, 32'hffff_ffff, 4'hf);
		cfg_read(8'h24);
		cfg_write(8'h34, 32'hffff_ffff, 4'hf);
		cfg_read(8'h34);
		cfg_write(8'h3c, 32'hffff_ffff, 4'hf);
		cfg_read(8'h3c);
		chk_word({24'h0, irq_line_out}, {24'h0, m_line});
		cfg_write(8'h30, 32'h1234_5678, 4'h3);
		cfg_write(8'h30, 32'h9abc_def0, 4'hc);
		cfg_read(8'h30);
		cfg_write(8'h28, $urandom, 4'hf);
		cfg_read(8'h28);
		repeat (40) begin
			cfg_write(offs[$urandom_range(6)], $urandom, 4'($urandom));
			cfg_read(offs[$urandom_range(6)]);
		end
		// loader is refused on an upstream port, taken on a downstream one
		ld_pin_value = 8'h5a;
		ld_pin_valid = 1'b1;
		@(negedge sys_clk);
		ld_pin_valid = 1'b0;
		cfg_read(8'h3c);
		port_is_downstream = 1'b1;
		repeat (4) @(negedge sys_clk);
		ld_pin_value = 8'h01;
		ld_pin_valid = 1'b1;
		m_pin = 8'h01;
		@(negedge sys_clk);
		ld_pin_valid = 1'b0;
		cfg_read(8'h3c);
		// windows: near-equal upper halves so both edges are reachable
		repeat (30) begin
			w = $urandom;
			cfg_write(8'h28, w, 4'hf);
			cfg_write(8'h2c, w + 32'($urandom_range(1)), 4'hf);
			cfg_write(8'h24, $urandom, 4'hf);
			cfg_write(8'h30, $urandom, 4'hf);
			io_base_low = 16'($urandom);
			io_limit_low = 16'($urandom);
			@(negedge sys_clk);
			edges();
		end
		// inverted window must stay empty
		cfg_write(8'h28, 32'h0000_0002, 4'hf);
		cfg_write(8'h2c, 32'h0000_0001, 4'hf);
		cfg_write(8'h30, 32'h0001_0002, 4'hf);
		@(negedge sys_clk);
		edges();
		// second reset in mid-run
		do_reset();
		foreach (offs[i]) cfg_read(offs[i]);
		complete_run();
	end

	// run takes well under 1 ms
	initial begin
		#5000000;
		err_total++;
		complete_run();
	end

endmodule

`default_nettype wire
